// ### common/spt_pkg.sv
package spt_pkg;

   localparam int SPT_SECTIONS    = 8;
   localparam int SPT_EVT_W       = 8;
   localparam int SPT_TIME_W      = 40;
   localparam int SPT_COUNT_W     = 32;
   localparam int SPT_TICK_W      = 4;
   localparam int SPT_RESID_W     = 8;
   localparam int SPT_BIT_CNT_W   = 6;

   localparam int SPT_CLK_PERIOD_NS = 100;
   localparam int SPT_UNIT_NS       = 10;
   localparam int SPT_RES_10_NS     = 10;
   localparam int SPT_RES_20_NS     = 20;
   localparam int SPT_RES_40_NS     = 40;
   localparam int SPT_RES_80_NS     = 80;
   localparam int SPT_RES_160_NS    = 160;
   localparam int SPT_RES_1600_NS   = 1600;

   // Clock period and the 1.6 us resolution in units of the finest resolution; the other resolutions as log2 shifts.
   localparam logic [SPT_RESID_W-1:0] SPT_CLK_UNITS = SPT_RESID_W'(SPT_CLK_PERIOD_NS / SPT_UNIT_NS);
   localparam logic [SPT_RESID_W-1:0] SPT_U_1600    = SPT_RESID_W'(SPT_RES_1600_NS / SPT_UNIT_NS);
   localparam int SPT_SH_10  = $clog2(SPT_RES_10_NS / SPT_UNIT_NS);
   localparam int SPT_SH_20  = $clog2(SPT_RES_20_NS / SPT_UNIT_NS);
   localparam int SPT_SH_40  = $clog2(SPT_RES_40_NS / SPT_UNIT_NS);
   localparam int SPT_SH_80  = $clog2(SPT_RES_80_NS / SPT_UNIT_NS);
   localparam int SPT_SH_160 = $clog2(SPT_RES_160_NS / SPT_UNIT_NS);

   typedef enum logic [2:0] {SPT_RES_10, SPT_RES_20, SPT_RES_40, SPT_RES_80, SPT_RES_160, SPT_RES_1600} spt_res_t;
   localparam spt_res_t SPT_RES_RESET = SPT_RES_10;

   typedef enum logic [1:0] {SPT_MODE_BETWEEN, SPT_MODE_START_START, SPT_MODE_RUN_END, SPT_MODE_COUNT} spt_mode_t;

   typedef enum logic {SPT_DIV_IDLE, SPT_DIV_BUSY} spt_div_st_t;

   typedef struct packed {
      logic                 enable;
      spt_mode_t            mode;
      logic [SPT_EVT_W-1:0] start_mask;
      logic [SPT_EVT_W-1:0] end_mask;
   } spt_cfg_t;

   typedef struct packed {
      logic [SPT_TIME_W-1:0]  total;
      logic [SPT_COUNT_W-1:0] count;
      logic [SPT_TIME_W-1:0]  max;
      logic [SPT_TIME_W-1:0]  min;
   } spt_result_t;

endpackage

// ### logic/spt_section.sv
`timescale 1ns/10ps
module spt_section
   import spt_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  ce,
   input  wire logic                  run,
   input  wire logic                  run_rise,
   input  wire logic [SPT_TICK_W-1:0] ticks,
   input  wire logic                  start_hit,
   input  wire logic                  end_hit,
   input  wire logic                  clear,
   input  wire spt_cfg_t              cfg,
   output spt_result_t                result,
   output logic                       active
);

   spt_result_t           res_reg;
   spt_result_t           res_next;
   logic                  active_reg;
   logic                  active_next;
   logic [SPT_TIME_W-1:0] cur_reg;
   logic [SPT_TIME_W-1:0] cur_next;
   logic [SPT_TIME_W-1:0] cur_inc;
   logic                  timing;
   logic                  close;

   function automatic logic [SPT_TIME_W-1:0] sat_add(input logic [SPT_TIME_W-1:0] a,
                                                     input logic [SPT_TICK_W-1:0] b);
      logic [SPT_TIME_W:0] s;
      s = {1'b0, a} + {{(SPT_TIME_W+1-SPT_TICK_W){1'b0}}, b};
      sat_add = s[SPT_TIME_W] ? {SPT_TIME_W{1'b1}} : s[SPT_TIME_W-1:0];
   endfunction

   always_comb
   begin
      res_next    = res_reg;
      active_next = active_reg;
      timing      = cfg.enable && run && active_reg && (cfg.mode != SPT_MODE_COUNT);
      cur_inc     = timing ? sat_add(cur_reg, ticks) : cur_reg;
      cur_next    = cur_inc;
      close       = 1'b0;
      if (timing)
         res_next.total = sat_add(res_reg.total, ticks);
      if (cfg.enable && run)
      begin
         case (cfg.mode)
            SPT_MODE_BETWEEN:
            begin
               if (active_reg && end_hit)
               begin
                  close       = 1'b1;
                  active_next = 1'b0;
               end
               else if (!active_reg && start_hit)
                  active_next = 1'b1;
            end
            SPT_MODE_START_START:
            begin
               if (active_reg && (start_hit || end_hit))
               begin
                  close       = 1'b1;
                  active_next = start_hit;
               end
               else if (!active_reg && start_hit)
                  active_next = 1'b1;
            end
            SPT_MODE_RUN_END:
            begin
               if (active_reg && end_hit)
               begin
                  close       = 1'b1;
                  active_next = 1'b0;
               end
               else if (run_rise)
                  active_next = 1'b1;
            end
            SPT_MODE_COUNT:
            begin
               active_next = 1'b0;
               if (start_hit)
                  res_next.count = (res_reg.count == '1) ? res_reg.count : res_reg.count + 1'b1;
            end
            default:
               active_next = 1'b0;
         endcase
      end
      if (!cfg.enable)
         active_next = 1'b0;
      if (close)
      begin
         res_next.count = (res_reg.count == '1) ? res_reg.count : res_reg.count + 1'b1;
         if (cur_inc > res_reg.max)
            res_next.max = cur_inc;
         if (cur_inc < res_reg.min)
            res_next.min = cur_inc;
         cur_next = '0;
      end
      else if (!active_reg)
         cur_next = '0;
      if (clear)
      begin
         res_next    = '{total: '0, count: '0, max: '0, min: '1};
         active_next = 1'b0;
         cur_next    = '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         res_reg    <= '{total: '0, count: '0, max: '0, min: '1};
         active_reg <= 1'b0;
         cur_reg    <= '0;
      end
      else if (ce)
      begin
         res_reg    <= res_next;
         active_reg <= active_next;
         cur_reg    <= cur_next;
      end
   end

   assign result = res_reg;
   assign active = active_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_clear_zeroes_all: assert property (ce && clear |=> res_reg.total == 0 && res_reg.count == 0 && !active_reg)
      else $error("section not cleared");
   a_disabled_stays_idle: assert property (ce && !clear && !cfg.enable
      |=> !active_reg && $stable(res_reg.total))
      else $error("disabled section measured");
   a_count_holds_max: assert property (ce && !clear && res_reg.count == '1 |=> res_reg.count == '1)
      else $error("pass counter wrapped");
   a_total_holds_max: assert property (ce && !clear && res_reg.total == '1 |=> res_reg.total == '1)
      else $error("time accumulator wrapped");
   a_halt_keeps_total: assert property (ce && !run && !clear
      |=> $stable(res_reg.total) && $stable(res_reg.count))
      else $error("result changed while halted");
   a_end_counts_one: assert property (ce && !clear && run && cfg.enable && cfg.mode == SPT_MODE_BETWEEN
      && active_reg && end_hit && res_reg.count != '1 |=> res_reg.count == $past(res_reg.count) + 1'b1)
      else $error("end event not counted once");
   a_total_adds_ticks: assert property (ce && !clear && timing && !res_reg.total[SPT_TIME_W-1]
      |=> res_reg.total == $past(res_reg.total) + $past(ticks))
      else $error("accumulator step wrong");
   a_max_above_min: assert property (res_reg.count != 0 && cfg.mode != SPT_MODE_COUNT
      && res_reg.min != '1 |-> res_reg.max >= res_reg.min)
      else $error("max below min");

   c_pass_closed: cover property (ce && close);
   c_resume_active: cover property (ce && active_reg && !run ##1 ce && run && active_reg);
endmodule

// ### logic/spt_top.sv
`timescale 1ns/10ps
// Functional notes
// - Eight sections; one resolution setting shared by all of them.
// - Each section runs in one of four condition modes bounded by events.
// - Any event match counts once at a section boundary.
// - Start and end each accept several events; any one triggers.
// - Resolution 10, 20, 40, 80, 160 ns or 1.6 us; 10 ns after reset.
// - Section time accumulates in 40 bits, once per resolution tick.
// - Pass counts held in a 32-bit counter.
// - Measuring starts by itself when target execution runs.
// - After a halt, resumed time adds onto accumulated results.
// - Clear one chosen section, or all sections at once.
// - Each section has an enable; disabled sections do not measure.
// - Measured time may be off by one resolution tick either way.
// - Each section yields maximum, minimum, average, total time and count.
module spt_top
   import spt_pkg::*;
#(
   parameter int NSEC = SPT_SECTIONS
)
(
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic                      ce,
   input  wire logic                      run,
   input  wire logic [SPT_EVT_W-1:0]      events,
   input  wire spt_res_t                  res_sel,
   input  wire spt_cfg_t                  cfg       [NSEC],
   input  wire logic                      clr_one,
   input  wire logic [$clog2(NSEC)-1:0]   clr_idx,
   input  wire logic                      clr_all,
   output spt_result_t                    result    [NSEC],
   output logic [SPT_TIME_W-1:0]          average   [NSEC],
   output logic [NSEC-1:0]                active
);

   localparam int IW = $clog2(NSEC);

   logic                   run_reg;
   logic                   run_next;
   logic [SPT_RESID_W-1:0] resid_reg;
   logic [SPT_RESID_W-1:0] resid_next;
   logic [SPT_RESID_W-1:0] sum;
   logic [SPT_TICK_W-1:0]  ticks;
   logic                   run_rise;
   spt_res_t               sel_reg;
   spt_res_t               sel_next;
   logic [SPT_RESID_W-1:0] resid_eff;

   // The clock is coarser than the finest resolution, so each cycle adds a whole number
   // of ticks and carries the remainder; the error never exceeds one tick.
   // A remainder left by another resolution is dropped, since it would overflow the tick count.
   always_comb
   begin
      resid_eff  = (res_sel == sel_reg) ? resid_reg : '0;
      sum        = resid_eff + SPT_CLK_UNITS;
      ticks      = '0;
      resid_next = resid_eff;
      sel_next   = res_sel;
      run_next   = run;
      run_rise   = run && !run_reg;
      if (run)
      begin
         case (res_sel)
            SPT_RES_10:
            begin
               ticks      = SPT_TICK_W'(sum >> SPT_SH_10);
               resid_next = '0;
            end
            SPT_RES_20:
            begin
               ticks      = SPT_TICK_W'(sum >> SPT_SH_20);
               resid_next = sum & SPT_RESID_W'(1);
            end
            SPT_RES_40:
            begin
               ticks      = SPT_TICK_W'(sum >> SPT_SH_40);
               resid_next = sum & SPT_RESID_W'(3);
            end
            SPT_RES_80:
            begin
               ticks      = SPT_TICK_W'(sum >> SPT_SH_80);
               resid_next = sum & SPT_RESID_W'(7);
            end
            SPT_RES_160:
            begin
               ticks      = SPT_TICK_W'(sum >> SPT_SH_160);
               resid_next = sum & SPT_RESID_W'(15);
            end
            SPT_RES_1600:
            begin
               ticks      = (sum >= SPT_U_1600) ? SPT_TICK_W'(1) : '0;
               resid_next = (sum >= SPT_U_1600) ? sum - SPT_U_1600 : sum;
            end
            default:
            begin
               ticks      = '0;
               resid_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         resid_reg <= '0;
         sel_reg   <= SPT_RES_RESET;
         run_reg   <= 1'b0;
      end
      else if (ce)
      begin
         resid_reg <= resid_next;
         sel_reg   <= sel_next;
         run_reg   <= run_next;
      end
   end

   // One shared tick stream feeds every section; conditions are assumed static while running.
   for (genvar g = 0; g < NSEC; g++)
   begin : g_sec
      spt_section u_sec
      (
         .clk       (clk),
         .reset_n   (reset_n),
         .ce        (ce),
         .run       (run),
         .run_rise  (run_rise),
         .ticks     (ticks),
         .start_hit (|(events & cfg[g].start_mask)),
         .end_hit   (|(events & cfg[g].end_mask)),
         .clear     (clr_all || (clr_one && clr_idx == IW'(g))),
         .cfg       (cfg[g]),
         .result    (result[g]),
         .active    (active[g])
      );
   end

   // Averages are produced by one serial divider that visits the sections in turn.
   spt_div_st_t             div_st_reg;
   spt_div_st_t             div_st_next;
   logic [IW-1:0]           idx_reg;
   logic [IW-1:0]           idx_next;
   logic [SPT_BIT_CNT_W-1:0] bit_reg;
   logic [SPT_BIT_CNT_W-1:0] bit_next;
   logic [SPT_COUNT_W:0]    rem_reg;
   logic [SPT_COUNT_W:0]    rem_next;
   logic [SPT_TIME_W-1:0]   quo_reg;
   logic [SPT_TIME_W-1:0]   quo_next;
   logic [SPT_COUNT_W-1:0]  dvs_reg;
   logic [SPT_COUNT_W-1:0]  dvs_next;
   logic [SPT_TIME_W-1:0]   avg_reg  [NSEC];
   logic [SPT_TIME_W-1:0]   avg_next [NSEC];
   logic [SPT_COUNT_W:0]    shifted;

   always_comb
   begin
      div_st_next = div_st_reg;
      idx_next    = idx_reg;
      bit_next    = bit_reg;
      rem_next    = rem_reg;
      quo_next    = quo_reg;
      dvs_next    = dvs_reg;
      avg_next    = avg_reg;
      shifted     = {rem_reg[SPT_COUNT_W-1:0], quo_reg[SPT_TIME_W-1]};
      case (div_st_reg)
         SPT_DIV_IDLE:
         begin
            rem_next = '0;
            quo_next = result[idx_reg].total;
            dvs_next = result[idx_reg].count;
            bit_next = SPT_BIT_CNT_W'(SPT_TIME_W);
            if (result[idx_reg].count == '0)
            begin
               avg_next[idx_reg] = '0;
               idx_next          = (idx_reg == IW'(NSEC - 1)) ? '0 : idx_reg + 1'b1;
            end
            else
               div_st_next = SPT_DIV_BUSY;
         end
         SPT_DIV_BUSY:
         begin
            if (shifted >= {1'b0, dvs_reg})
            begin
               rem_next = shifted - {1'b0, dvs_reg};
               quo_next = {quo_reg[SPT_TIME_W-2:0], 1'b1};
            end
            else
            begin
               rem_next = shifted;
               quo_next = {quo_reg[SPT_TIME_W-2:0], 1'b0};
            end
            bit_next = bit_reg - 1'b1;
            if (bit_reg == SPT_BIT_CNT_W'(1))
            begin
               avg_next[idx_reg] = quo_next;
               idx_next          = (idx_reg == IW'(NSEC - 1)) ? '0 : idx_reg + 1'b1;
               div_st_next       = SPT_DIV_IDLE;
            end
         end
         default:
            div_st_next = SPT_DIV_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_st_reg <= SPT_DIV_IDLE;
         idx_reg    <= '0;
         bit_reg    <= '0;
         rem_reg    <= '0;
         quo_reg    <= '0;
         dvs_reg    <= '0;
         avg_reg    <= '{default: '0};
      end
      else if (ce)
      begin
         div_st_reg <= div_st_next;
         idx_reg    <= idx_next;
         bit_reg    <= bit_next;
         rem_reg    <= rem_next;
         quo_reg    <= quo_next;
         dvs_reg    <= dvs_next;
         avg_reg    <= avg_next;
      end
   end

   assign average = avg_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_halt_no_ticks: assert property (!run |-> ticks == '0)
      else $error("ticks while halted");
   a_fine_tick_rate: assert property (run && res_sel == SPT_RES_10 |-> ticks == SPT_TICK_W'(SPT_CLK_UNITS))
      else $error("10 ns rate wrong");
   a_coarse_tick_rate: assert property (ce && run && res_sel == SPT_RES_1600 && ticks != '0
      |=> ticks == '0)
      else $error("1.6 us ticks too fast");
   a_div_bounded: assert property (ce && div_st_reg == SPT_DIV_IDLE ##1 div_st_reg == SPT_DIV_BUSY
      |-> ##[1:300] div_st_reg == SPT_DIV_IDLE)
      else $error("divider stuck");

   c_all_cleared: cover property (ce && clr_all && run);
   c_avg_written: cover property (ce && div_st_reg == SPT_DIV_BUSY && bit_reg == SPT_BIT_CNT_W'(1));
   c_slow_res_run: cover property (run && res_sel == SPT_RES_1600 && ticks != '0);
endmodule

// ### sim/spt_evt_model.sv
`timescale 1ns/10ps
module spt_evt_model
   import spt_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 go,
   input  wire logic                 fire,
   input  wire logic [2:0]           fire_idx,
   output logic                      run,
   output logic [SPT_EVT_W-1:0]      events
);
   logic                 run_reg;
   logic                 run_next;
   logic [SPT_EVT_W-1:0] events_reg;
   logic [SPT_EVT_W-1:0] events_next;

   // A detector match is one single-cycle pulse; a held match would count again.
   always_comb
   begin
      run_next    = go;
      events_next = fire ? (SPT_EVT_W'(1) << fire_idx) : '0;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         run_reg    <= 1'b0;
         events_reg <= '0;
      end
      else
      begin
         run_reg    <= run_next;
         events_reg <= events_next;
      end
   end

   assign run    = run_reg;
   assign events = events_reg;
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb
   import spt_pkg::*;
;
   typedef struct packed {
      logic                  active;
      logic [SPT_TIME_W-1:0] plen;
      spt_result_t           r;
   } spt_ref_t;
   localparam spt_ref_t REF_INIT = '{active: 1'b0, plen: '0, r: '{total: '0, count: '0, max: '0, min: '1}};
   localparam int       RES_NS [6] = '{SPT_RES_10_NS, SPT_RES_20_NS, SPT_RES_40_NS, SPT_RES_80_NS,
                                       SPT_RES_160_NS, SPT_RES_1600_NS};

   logic                  clk;
   logic                  reset_n;
   logic                  ce;
   logic                  go;
   logic                  fire;
   logic [2:0]            fire_idx;
   logic                  run;
   logic [SPT_EVT_W-1:0]  events;
   spt_res_t              res_sel;
   spt_cfg_t              cfg     [SPT_SECTIONS];
   logic                  clr_one;
   logic [2:0]            clr_idx;
   logic                  clr_all;
   spt_result_t           result  [SPT_SECTIONS];
   logic [SPT_TIME_W-1:0] average [SPT_SECTIONS];
   logic [SPT_SECTIONS-1:0] active;
   spt_ref_t              ref_s   [SPT_SECTIONS];
   logic [15:0]           lfsr;
   logic [7:0]            smask;
   int                    err_count;
   int                    n_tests;

   spt_evt_model u_evt (.clk(clk), .reset_n(reset_n), .go(go), .fire(fire), .fire_idx(fire_idx),
                        .run(run), .events(events));

   spt_top #(.NSEC(SPT_SECTIONS)) DUT (.clk(clk), .reset_n(reset_n), .ce(ce), .run(run), .events(events),
      .res_sel(res_sel), .cfg(cfg), .clr_one(clr_one), .clr_idx(clr_idx), .clr_all(clr_all),
      .result(result), .average(average), .active(active));

   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // Expected section state after one enabled edge, between-events mode at 10 ns.
   function automatic spt_ref_t ref_step(input spt_ref_t s, input spt_cfg_t c, input logic r,
                                         input logic [SPT_EVT_W-1:0] ev, input logic clr);
      spt_ref_t n;
      n = s;
      if (clr)
         n = REF_INIT;
      else if (r && c.enable)
      begin
         if (s.active)
         begin
            n.r.total = s.r.total + 40'd10;
            n.plen    = s.plen + 40'd10;
            if (|(ev & c.end_mask))
            begin
               n.active  = 1'b0;
               n.r.count = s.r.count + 32'd1;
               if (n.plen > n.r.max)
                  n.r.max = n.plen;
               if (n.plen < n.r.min)
                  n.r.min = n.plen;
            end
         end
         else if (|(ev & c.start_mask))
         begin
            n.active = 1'b1;
            n.plen   = '0;
         end
      end
      return n;
   endfunction

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         foreach (ref_s[i]) ref_s[i] = REF_INIT;
      else if (ce)
         foreach (ref_s[i])
            ref_s[i] = ref_step(ref_s[i], cfg[i], run, events,
                                clr_all || (clr_one && clr_idx == 3'(i)));
   end

   task automatic cmp_val(input logic [SPT_TIME_W-1:0] got, input logic [SPT_TIME_W-1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_res(input spt_result_t got, input spt_result_t exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_near(input logic [SPT_TIME_W-1:0] got, input int ideal);
      n_tests++;
      if ((got >= 40'(ideal - 1) && got <= 40'(ideal + 1)) !== 1'b1)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, 40'(ideal));
      end
   endtask

   task automatic cmp_all();
      foreach (result[i])
      begin
         cmp_res(result[i], ref_s[i].r);
         cmp_val(40'(active[i]), 40'(ref_s[i].active));
      end
   endtask

   task automatic evt(input int idx, input int gap);
      @(posedge clk);
      fire     <= 1'b1;
      fire_idx <= 3'(idx);
      @(posedge clk);
      fire <= 1'b0;
      repeat (gap - 2) @(posedge clk);
   endtask

   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      err_count++;
      wrap_up();
   end

   initial
   begin
      err_count = 0;
      n_tests   = 0;
      lfsr      = 16'h2288;
      reset_n   = 1'b0;
      ce        = 1'b1;
      go        = 1'b0;
      fire      = 1'b0;
      fire_idx  = 3'h0;
      clr_one   = 1'b0;
      clr_idx   = 3'h0;
      clr_all   = 1'b0;
      res_sel   = SPT_RES_RESET;
      foreach (cfg[i]) cfg[i] = '0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      foreach (result[i]) cmp_res(result[i], REF_INIT.r);
      cmp_val(40'(active), 40'h0);
      @(posedge clk);
      reset_n <= 1'b1;
      $display("test reset done");

      // Conditions change only while the target is halted.
      cfg[0] <= '{1'b1, SPT_MODE_BETWEEN, 8'h01, 8'h06};
      for (int r = 0; r < 6; r++)
      begin
         @(posedge clk);
         res_sel <= spt_res_t'(r);
         clr_all <= 1'b1;
         @(posedge clk);
         clr_all <= 1'b0;
         go      <= 1'b1;
         repeat (3) @(posedge clk);
         evt(0, 64);
         evt(1 + r % 2, 2);
         go <= 1'b0;
         repeat (4) @(posedge clk);
         @(negedge clk);
         chk_near(result[0].total, 6400 / RES_NS[r]);
         cmp_val(40'(result[0].count), 40'h1);
      end
      $display("test resolution done");

      @(posedge clk);
      res_sel <= SPT_RES_10;
      clr_all <= 1'b1;
      cfg[0]  <= '{1'b1, SPT_MODE_START_START, 8'h01, 8'h00};
      cfg[1]  <= '{1'b1, SPT_MODE_RUN_END, 8'h01, 8'h02};
      cfg[2]  <= '{1'b1, SPT_MODE_COUNT, 8'h01, 8'h02};
      @(posedge clk);
      clr_all <= 1'b0;
      go      <= 1'b1;
      repeat (3) @(posedge clk);
      evt(0, 5);
      evt(0, 7);
      evt(1, 4);
      evt(0, 3);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      cmp_val(40'(result[0].count), 40'h2);
      cmp_val(result[0].max, 40'h6e);
      cmp_val(result[0].min, 40'h32);
      cmp_val(40'(result[1].count), 40'h1);
      cmp_val(40'(result[2].count), 40'h3);
      $display("test modes done");

      @(posedge clk);
      clr_all <= 1'b1;
      foreach (cfg[i])
      begin
         lfsr   = lfsr_next(lfsr);
         smask  = lfsr[7:0] | (8'h01 << i);
         cfg[i] <= '{i != 7, SPT_MODE_BETWEEN, smask, ~smask};
      end
      @(posedge clk);
      clr_all <= 1'b0;
      for (int k = 0; k < 800; k++)
      begin
         @(posedge clk);
         lfsr = lfsr_next(lfsr);
         ce       <= lfsr[3:0] != 4'h0;
         go       <= (lfsr[7:4] == 4'h0) ? ~go : (k < 4) ? 1'b1 : go;
         fire     <= lfsr[8];
         fire_idx <= lfsr[11:9];
         clr_one  <= lfsr[15:12] == 4'h0;
         clr_idx  <= lfsr[2:0];
         clr_all  <= (k % 257) == 256;
         if (k % 100 == 99)
         begin
            @(negedge clk);
            cmp_all();
         end
      end
      @(posedge clk);
      go      <= 1'b0;
      ce      <= 1'b1;
      clr_one <= 1'b0;
      clr_all <= 1'b0;
      fire    <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      cmp_all();
      $display("test random done");

      repeat (400) @(posedge clk);
      @(negedge clk);
      foreach (average[i])
         cmp_val(average[i], (ref_s[i].r.count != 0) ? ref_s[i].r.total / 40'(ref_s[i].r.count) : '0);
      $display("test average done");
      wrap_up();
   end
endmodule
